// ---- dv/eeprom_two_wire_slave_bus_tb_top.sv ----
// self-checking bench of the two-wire slave front end
// assumes the master model in dv/ and a shortened write cycle
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_slave_bus_tb_top;
  // ****************************************
  // signals and harness
  // ****************************************
  localparam int WC = 6000;
  typedef struct {logic [7:0] ctrl; logic nack;} row_t;
  row_t rows [5] = '{'{8'hA1, 1'b0}, '{8'h21, 1'b1}, '{8'hE1, 1'b1}, '{8'hB1, 1'b1},
                     '{8'hA7, 1'b0}};
  logic mclk, srst, drain_clk, drain_rst, scl, sda_low, sda_o, sda_oe, write_busy, page_valid;
  logic page_ready = 1'b0;
  logic scl_d = 1'b1;
  logic oe_d = 1'b0;
  logic [7:0] page_data;
  logic [7:0] got_q [$];
  wire sda;
  int n_mismatch = 0;
  int num_checks = 0;
  int stall = 0;
  int low_cnt = 0;
  int busy_cnt = 0;

  // pull-up wire: low when either party pulls
  assign sda = ~sda_low & ~(sda_oe & ~sda_o);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    drain_clk = 1'b0;
    #7.3;
    forever #16 drain_clk = ~drain_clk;
  end

  eeprom_slave_bus #(.WC_CYC(WC)) DUT (.mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .write_busy(write_busy), .drain_clk(drain_clk),
    .drain_rst(drain_rst), .page_data(page_data), .page_valid(page_valid),
    .page_ready(page_ready));
  two_wire_master_model M (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] wval(input int k);
    return 8'h3C + 8'(k * 13);
  endfunction

  // buffer is circular over the kept bytes 1..16, so byte 16 is followed by byte 1
  function automatic logic [7:0] after(input logic [7:0] b);
    after = 8'hXX;
    for (int k = 1; k <= 16; k++) if (wval(k) === b) after = wval(k % 16 + 1);
  endfunction

  // ****************************************
  // monitors and page sink
  // ****************************************
  // sink takes one edge in four, so the two-entry buffer fills and back-pressures
  always @(posedge drain_clk) begin
    stall <= stall + 1;
    page_ready <= (stall % 4 == 3);
    if (page_valid === 1'b1 && page_ready) got_q.push_back(page_data);
  end

  always @(posedge mclk) begin
    scl_d <= scl;
    oe_d <= sda_oe;
    low_cnt <= (scl_d && !scl) ? 0 : low_cnt + 1;
    if (write_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (!srst && sda_oe !== oe_d && !scl) check({7'h0, low_cnt >= 74}, 8'h01, "drive delay");
  end

  // the sequence needs about 76k cycles
  initial begin
    repeat (90000) @(posedge mclk);
    check(8'h00, 8'h01, "timeout");
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] rx, b0;
    logic a;
    int rp;
    rp = 0;
    srst = 1'b1;
    drain_rst = 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge drain_clk);
    drain_rst <= 1'b0;
    repeat (20) @(posedge mclk);
    check({5'h0, sda_oe, write_busy, page_valid}, 8'h00, "reset outputs");
    // overlong page: 17 bytes, the first must be displaced
    M.start();
    M.xfer(8'hA0, 1'b1, 1'b0, rx, a);
    check(a, 8'h00, "write control ack");
    for (int k = 0; k < 17; k++) begin
      M.xfer(wval(k), 1'b1, 1'b0, rx, a);
      check(a, 8'h00, "data ack");
    end
    M.stop();
    check(write_busy, 8'h01, "write cycle running");
    M.start();
    M.xfer(8'hA0, 1'b1, 1'b0, rx, a);
    check(a, 8'h01, "ack withheld while busy");
    M.stop();
    for (int k = 0; k < WC && write_busy !== 1'b0; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    check(8'(busy_cnt == WC), 8'h01, "write cycle length");
    check(8'(got_q.size()), 8'h10, "page byte count");
    foreach (got_q[i]) check(got_q[i], wval(i + 1), "page byte order");
    // control codes; first row carries a spike shorter than the filter
    for (int r = 0; r < 5; r++) begin
      M.start();
      M.xfer(rows[r].ctrl, 1'b1, r == 0, rx, a);
      check(a, rows[r].nack, "control code");
      if (!rows[r].nack) begin
        M.xfer(8'hFF, 1'b0, 1'b0, b0, a);
        // read pointer runs on from slot 0, which holds the sixteenth byte kept
        check(b0, wval((rp + 15) % 16 + 1), "read byte");
        M.xfer(8'hFF, 1'b1, 1'b0, rx, a);
        check(rx, after(b0), "read sequence");
        rp += 2;
      end
      M.stop();
      check(sda, 8'h01, "line released at stop");
    end
    // mid-run reset on an idle bus: pointers restart, stored bytes stay
    @(posedge drain_clk);
    drain_rst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge drain_clk);
    drain_rst <= 1'b0;
    repeat (20) @(posedge mclk);
    check({5'h0, sda_oe, write_busy, page_valid}, 8'h00, "outputs after reset");
    M.start();
    M.xfer(8'hA1, 1'b1, 1'b0, rx, a);
    check(a, 8'h00, "ack after reset");
    M.xfer(8'hFF, 1'b1, 1'b0, rx, a);
    check(rx, wval(16), "read pointer after reset");
    M.stop();
    check({7'h0, sda_oe}, 8'h00, "released after reset read");
    stop_test();
  end
endmodule // eeprom_two_wire_slave_bus_tb_top
`default_nettype wire

// ---- dv/two_wire_master_model.sv ----
// bus master model: drives the serial clock, starts, stops, bits and acks
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model (
  // timing reference
  input wire logic mclk,
  // bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ****************************************
  // bit timing in mclk cycles
  // ****************************************
  // low phase long enough for the slave's delayed drive to settle before the rise
  localparam int T_SET = 25;
  localparam int T_LOW = 125;
  localparam int T_HIGH = 125;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ****************************************
  // bus conditions and bits
  // ****************************************
  // idle bus assumed on entry, or clock low after a bit
  task automatic start();
    wait_cyc(T_SET);
    sda_low <= 1'b0;
    wait_cyc(T_LOW - T_SET);
    scl <= 1'b1;
    wait_cyc(T_HIGH);
    sda_low <= 1'b1;
    wait_cyc(T_HIGH);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wait_cyc(T_SET);
    sda_low <= 1'b1;
    wait_cyc(T_LOW - T_SET);
    scl <= 1'b1;
    wait_cyc(T_HIGH);
    sda_low <= 1'b0;
    wait_cyc(T_HIGH);
  endtask

  // glitch: 40 ns spike on data in mid-high, shorter than the filter span
  task automatic bit_io(input logic b, input bit glitch, output logic got);
    wait_cyc(T_SET);
    sda_low <= ~b;
    wait_cyc(T_LOW - T_SET);
    scl <= 1'b1;
    wait_cyc(T_HIGH / 2);
    got = sda;
    if (glitch) begin
      sda_low <= b;
      wait_cyc(10);
      sda_low <= ~b;
    end
    wait_cyc(T_HIGH / 2);
    scl <= 1'b0;
  endtask

  // ack_in low acknowledges a read byte, high ends the read
  task automatic xfer(input logic [7:0] tx, input logic ack_in, input bit glitch,
                      output logic [7:0] rx, output logic ack_out);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], glitch && i == 4, g);
      rx[i] = g;
    end
    bit_io(ack_in, 1'b0, ack_out);
  endtask
endmodule // two_wire_master_model
`default_nettype wire

// ---- shared/eeprom_slave_pkg.sv ----
// constants, types and timing counts shared by the two-wire slave front end
// assumes a 250 MHz core clock; all bus timing is counted in core clock cycles
`default_nettype none
package eeprom_slave_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int MCLK_PERIOD_PS = 4000;
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int FILT_W = 4;
  localparam int TX_DLY_NS = 300;
  localparam int TX_DLY_CYC = (TX_DLY_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int DLY_W = 7;
  localparam int WC_MS = 5;
  localparam longint WC_CYC_L = (longint'(WC_MS) * 64'd1000000000) / MCLK_PERIOD_PS;
  localparam int WC_CYC = int'(WC_CYC_L);
  localparam int WC_W = 21;
  // ****************************************
  // framing and page buffer
  // ****************************************
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam int BYTE_W = 8;
  localparam int PAGE_AW = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [1:0] LINES_IDLE = 2'h3;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_CTRL = 3'h1,
    S_CACK = 3'h2,
    S_WRX  = 3'h3,
    S_WACK = 3'h4,
    S_TX   = 3'h5,
    S_MACK = 3'h6,
    S_SKIP = 3'h7
  } bus_state_t;
endpackage
`default_nettype wire

// ---- shared/page_mem_if.sv ----
// write and read port of the page buffer memory
// assumes one clock domain on both sides
`timescale 1ns/100ps
`default_nettype none
interface page_mem_if #(parameter int AW = 4, parameter int DW = 8);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- verilog/eeprom_slave_bus.sv ----
// two-wire slave front end: filtering, conditions, framing, ack, page buffer
// assumes open-drain sda resolved outside; received pages leave on drain_clk
`timescale 1ns/100ps
`default_nettype none
module eeprom_slave_bus #(
  parameter int WC_CYC = eeprom_slave_pkg::WC_CYC
) (
  // core clock and reset
  input wire logic mclk,
  input wire logic srst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // status
  output logic write_busy,
  // page stream out
  input wire logic drain_clk,
  input wire logic drain_rst,
  output logic [7:0] page_data,
  output logic page_valid,
  input wire logic page_ready
);
  // ****************************************
  // pin synchronisers and glitch filters
  // ****************************************
  logic [1:0] pin_s1_reg, pin_s2_reg, line_q_reg;
  wire [1:0] line_w;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_s1_reg <= eeprom_slave_pkg::LINES_IDLE;
      pin_s2_reg <= eeprom_slave_pkg::LINES_IDLE;
    end else begin
      pin_s1_reg <= {scl_i, sda_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  genvar g;
  for (g = 0; g < 2; g++) begin : g_flt
    logic f_reg, f_next;
    logic [eeprom_slave_pkg::FILT_W-1:0] c_reg, c_next;
    always_comb begin
      f_next = f_reg;
      c_next = '0;
      if (pin_s2_reg[g] != f_reg) begin
        // must differ for more than the spike width before it counts
        if (c_reg == 4'(eeprom_slave_pkg::FILT_CYC - 1)) begin
          f_next = pin_s2_reg[g];
        end else begin
          c_next = c_reg + 4'h1;
        end
      end
    end
    always_ff @(posedge mclk) begin
      if (srst) begin
        f_reg <= 1'b1;
        c_reg <= '0;
      end else begin
        f_reg <= f_next;
        c_reg <= c_next;
      end
    end
    assign line_w[g] = f_reg;
  end

  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
  assign scl_f = line_w[1];
  assign sda_f = line_w[0];
  assign scl_rise = scl_f & ~line_q_reg[1];
  assign scl_fall = ~scl_f & line_q_reg[1];
  assign start_det = scl_f & line_q_reg[1] & line_q_reg[0] & ~sda_f;
  assign stop_det = scl_f & line_q_reg[1] & ~line_q_reg[0] & sda_f;

  // ****************************************
  // bus engine, write cycle and page drain
  // ****************************************
  page_mem_if #(.AW(eeprom_slave_pkg::PAGE_AW), .DW(eeprom_slave_pkg::BYTE_W)) pm ();
  page_mem #(.AW(eeprom_slave_pkg::PAGE_AW), .DW(eeprom_slave_pkg::BYTE_W)) u_mem (
    .mclk(mclk),
    .p(pm.mem)
  );

  eeprom_slave_pkg::bus_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next, wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [3:0] dptr_reg, dptr_next;
  logic [4:0] cnt_reg, cnt_next, dleft_reg, dleft_next;
  logic [7:0] rx_reg, rx_next, tx_reg, tx_next;
  logic rw_reg, rw_next, nack_reg, nack_next, pend_reg, pend_next;
  logic oe_reg, oe_next, busy_reg, busy_next, fv_reg, fv_next;
  logic [eeprom_slave_pkg::DLY_W-1:0] dly_reg, dly_next;
  logic [eeprom_slave_pkg::WC_W-1:0] wc_reg, wc_next;
  logic mem_wr, buf_in_ready, can_ack;

  assign can_ack = ~busy_reg & (dleft_reg == 5'h00);
  assign pm.wr_en = mem_wr;
  assign pm.wr_addr = wptr_reg;
  assign pm.wr_data = rx_reg;
  assign pm.rd_addr = (dleft_reg != 5'h00) ? dptr_reg : rptr_reg;

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    dptr_next = dptr_reg;
    cnt_next = cnt_reg;
    dleft_next = dleft_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    pend_next = pend_reg;
    oe_next = oe_reg;
    busy_next = busy_reg;
    wc_next = wc_reg;
    dly_next = dly_reg;
    fv_next = 1'b0;
    mem_wr = 1'b0;
    // sda moves only a hold delay after scl falls
    if (scl_fall) begin
      dly_next = 7'(eeprom_slave_pkg::TX_DLY_CYC);
    end else if (dly_reg != '0) begin
      dly_next = dly_reg - 7'h01;
      if (dly_reg == 7'h01) begin
        oe_next = pend_reg;
      end
    end
    if (busy_reg) begin
      wc_next = wc_reg - 21'h000001;
      if (wc_reg == 21'h000001) begin
        busy_next = 1'b0;
      end
    end
    // one fetch in flight keeps the buffer from overrunning
    if (dleft_reg != 5'h00 && buf_in_ready && !fv_reg) begin
      fv_next = 1'b1;
      dptr_next = dptr_reg + 4'h1;
      dleft_next = dleft_reg - 5'h01;
    end
    if (start_det) begin
      state_next = eeprom_slave_pkg::S_CTRL;
      bit_next = 4'h0;
      pend_next = 1'b0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      if ((state_reg == eeprom_slave_pkg::S_WRX || state_reg == eeprom_slave_pkg::S_WACK)
          && cnt_reg != 5'h00 && can_ack) begin
        busy_next = 1'b1;
        wc_next = 21'(WC_CYC);
        dptr_next = wptr_reg - cnt_reg[3:0];
        dleft_next = cnt_reg;
      end
      state_next = eeprom_slave_pkg::S_IDLE;
      pend_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        eeprom_slave_pkg::S_CTRL, eeprom_slave_pkg::S_WRX: begin
          if (scl_rise && bit_reg != 4'h8) begin
            rx_next = {rx_reg[6:0], sda_f};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            if (state_reg == eeprom_slave_pkg::S_CTRL) begin
              rw_next = rx_reg[0];
              if (rx_reg[7:4] == eeprom_slave_pkg::CTRL_CODE && can_ack) begin
                state_next = eeprom_slave_pkg::S_CACK;
                pend_next = 1'b1;
                if (!rx_reg[0]) begin
                  wptr_next = 4'h0;
                  cnt_next = 5'h00;
                end
              end else begin
                state_next = eeprom_slave_pkg::S_SKIP;
              end
            end else begin
              mem_wr = 1'b1;
              wptr_next = wptr_reg + 4'h1;
              if (cnt_reg != 5'(eeprom_slave_pkg::PAGE_BYTES)) begin
                cnt_next = cnt_reg + 5'h01;
              end
              state_next = eeprom_slave_pkg::S_WACK;
              pend_next = 1'b1;
            end
          end
        end
        eeprom_slave_pkg::S_CACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              state_next = eeprom_slave_pkg::S_TX;
              tx_next = pm.rd_data;
              pend_next = ~pm.rd_data[7];
              rptr_next = rptr_reg + 4'h1;
            end else begin
              state_next = eeprom_slave_pkg::S_WRX;
              pend_next = 1'b0;
            end
          end
        end
        eeprom_slave_pkg::S_WACK: begin
          if (scl_fall) begin
            state_next = eeprom_slave_pkg::S_WRX;
            pend_next = 1'b0;
          end
        end
        eeprom_slave_pkg::S_TX: begin
          if (scl_fall) begin
            if (bit_reg == 4'h7) begin
              state_next = eeprom_slave_pkg::S_MACK;
              bit_next = 4'h0;
              pend_next = 1'b0;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              pend_next = ~tx_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        eeprom_slave_pkg::S_MACK: begin
          if (scl_rise) begin
            nack_next = sda_f;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = eeprom_slave_pkg::S_SKIP;
              pend_next = 1'b0;
            end else begin
              state_next = eeprom_slave_pkg::S_TX;
              tx_next = pm.rd_data;
              pend_next = ~pm.rd_data[7];
              rptr_next = rptr_reg + 4'h1;
            end
          end
        end
        eeprom_slave_pkg::S_IDLE, eeprom_slave_pkg::S_SKIP: begin
          pend_next = 1'b0;
        end
        default: begin
          state_next = eeprom_slave_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= eeprom_slave_pkg::S_IDLE;
      bit_reg <= 4'h0;
      wptr_reg <= 4'h0;
      rptr_reg <= 4'h0;
      dptr_reg <= 4'h0;
      cnt_reg <= 5'h00;
      dleft_reg <= 5'h00;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      pend_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      wc_reg <= '0;
      dly_reg <= '0;
      fv_reg <= 1'b0;
      line_q_reg <= eeprom_slave_pkg::LINES_IDLE;
      sda_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      dptr_reg <= dptr_next;
      cnt_reg <= cnt_next;
      dleft_reg <= dleft_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      pend_reg <= pend_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      wc_reg <= wc_next;
      dly_reg <= dly_next;
      fv_reg <= fv_next;
      line_q_reg <= line_w;
      sda_o <= 1'b0;
    end
  end
  assign sda_oe = oe_reg;
  assign write_busy = busy_reg;

  // ****************************************
  // two-entry buffer and handshake sender
  // ****************************************
  logic [7:0] b0_reg, b0_next, b1_reg, b1_next, hs_data_reg, hs_data_next;
  logic [1:0] bcnt_reg, bcnt_next, bmid;
  logic hs_req_reg, hs_req_next, ack_s1_reg, ack_s2_reg, ack_drain_reg, pop;

  assign buf_in_ready = bcnt_reg != 2'(eeprom_slave_pkg::BUF_DEPTH);
  assign pop = (bcnt_reg != 2'h0) & (hs_req_reg == ack_s2_reg);
  assign bmid = bcnt_reg - {1'b0, pop};

  always_comb begin
    b0_next = b0_reg;
    b1_next = b1_reg;
    hs_data_next = hs_data_reg;
    hs_req_next = hs_req_reg;
    if (pop) begin
      hs_data_next = b0_reg;
      hs_req_next = ~hs_req_reg;
      b0_next = b1_reg;
    end
    if (fv_reg) begin
      if (bmid == 2'h0) begin
        b0_next = pm.rd_data;
      end else begin
        b1_next = pm.rd_data;
      end
    end
    bcnt_next = bmid + {1'b0, fv_reg};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      b0_reg <= 8'h00;
      b1_reg <= 8'h00;
      bcnt_reg <= 2'h0;
      hs_data_reg <= 8'h00;
      hs_req_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      b0_reg <= b0_next;
      b1_reg <= b1_next;
      bcnt_reg <= bcnt_next;
      hs_data_reg <= hs_data_next;
      hs_req_reg <= hs_req_next;
      ack_s1_reg <= ack_drain_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // ****************************************
  // drain clock side
  // ****************************************
  logic rq_s1_reg, rq_s2_reg, seen_reg, seen_next, ack_drain_next, valid_next;
  logic [7:0] data_next;

  always_comb begin
    seen_next = seen_reg;
    ack_drain_next = ack_drain_reg;
    valid_next = page_valid;
    data_next = page_data;
    if (page_valid && page_ready) begin
      valid_next = 1'b0;
      ack_drain_next = seen_reg;
    end else if (!page_valid && rq_s2_reg != seen_reg) begin
      // sender holds its word until acknowledged, so it is stable here
      valid_next = 1'b1;
      data_next = hs_data_reg;
      seen_next = rq_s2_reg;
    end
  end

  always_ff @(posedge drain_clk) begin
    if (drain_rst) begin
      rq_s1_reg <= 1'b0;
      rq_s2_reg <= 1'b0;
      seen_reg <= 1'b0;
      ack_drain_reg <= 1'b0;
      page_valid <= 1'b0;
      page_data <= 8'h00;
    end else begin
      rq_s1_reg <= hs_req_reg;
      rq_s2_reg <= rq_s1_reg;
      seen_reg <= seen_next;
      ack_drain_reg <= ack_drain_next;
      page_valid <= valid_next;
      page_data <= data_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic [eeprom_slave_pkg::DLY_W-1:0] since_fall_reg;
  logic [eeprom_slave_pkg::WC_W-1:0] busy_age_reg;
  always_ff @(posedge mclk) begin
    if (srst || scl_fall) begin
      since_fall_reg <= '0;
    end else if (since_fall_reg != 7'h7F) begin
      since_fall_reg <= since_fall_reg + 7'h01;
    end
    if (srst || !busy_reg) begin
      busy_age_reg <= '0;
    end else begin
      busy_age_reg <= busy_age_reg + 21'h000001;
    end
  end

  property p_start;
    @(posedge mclk) disable iff (srst) start_det |=> state_reg == eeprom_slave_pkg::S_CTRL;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop;
    @(posedge mclk) disable iff (srst) stop_det |=> state_reg == eeprom_slave_pkg::S_IDLE && !oe_reg;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_hold;
    @(posedge mclk) disable iff (srst) $changed(oe_reg) && !$past(start_det) && !$past(stop_det)
      |-> since_fall_reg >= 7'(eeprom_slave_pkg::TX_DLY_CYC);
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved too soon");
  property p_busy_quiet;
    @(posedge mclk) disable iff (srst) busy_reg |-> !oe_reg;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
  property p_wc;
    @(posedge mclk) disable iff (srst) busy_age_reg <= 21'(WC_CYC);
  endproperty
  a_wc: assert property (p_wc) else $error("write cycle too long");
  property p_code;
    @(posedge mclk) disable iff (srst) state_reg == eeprom_slave_pkg::S_CTRL && scl_fall
      && bit_reg == 4'h8 && rx_reg[7:4] != eeprom_slave_pkg::CTRL_CODE && !start_det && !stop_det
      |=> state_reg == eeprom_slave_pkg::S_SKIP;
  endproperty
  a_code: assert property (p_code) else $error("foreign code answered");
  property p_rw;
    @(posedge mclk) disable iff (srst) state_reg == eeprom_slave_pkg::S_CACK && scl_fall
      && !start_det && !stop_det |=> state_reg == (rw_reg ? eeprom_slave_pkg::S_TX
      : eeprom_slave_pkg::S_WRX);
  endproperty
  a_rw: assert property (p_rw) else $error("wrong direction");
  property p_nack;
    @(posedge mclk) disable iff (srst) state_reg == eeprom_slave_pkg::S_MACK && scl_fall
      && nack_reg && !start_det && !stop_det |=> !pend_reg ##75 !oe_reg;
  endproperty
  a_nack: assert property (p_nack) else $error("sda held after nack");
  property p_ack_low;
    @(posedge mclk) disable iff (srst) (state_reg == eeprom_slave_pkg::S_WACK
      || state_reg == eeprom_slave_pkg::S_CACK) && scl_rise |-> oe_reg;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not low");
  property p_cnt;
    @(posedge mclk) disable iff (srst) cnt_reg <= 5'(eeprom_slave_pkg::PAGE_BYTES);
  endproperty
  a_cnt: assert property (p_cnt) else $error("page count overflow");
  property p_filt;
    @(posedge mclk) disable iff (srst) $changed(sda_f) |-> $past(pin_s2_reg[0], 1) == sda_f
      && $past(pin_s2_reg[0], 13) == sda_f;
  endproperty
  a_filt: assert property (p_filt) else $error("spike passed");

  c_write: cover property (@(posedge mclk) disable iff (srst) $rose(busy_reg));
  c_wrap: cover property (@(posedge mclk) disable iff (srst)
    cnt_reg == 5'(eeprom_slave_pkg::PAGE_BYTES) && mem_wr);
  c_read_nack: cover property (@(posedge mclk) disable iff (srst)
    state_reg == eeprom_slave_pkg::S_MACK ##1 state_reg == eeprom_slave_pkg::S_SKIP);
  c_drain_full: cover property (@(posedge mclk) disable iff (srst) bcnt_reg == 2'h2);
endmodule // eeprom_slave_bus
`default_nettype wire

// ---- verilog/page_mem.sv ----
// page buffer storage: one write port, one registered read port
// assumes addresses stable for one clock before data is wanted
`timescale 1ns/100ps
`default_nettype none
module page_mem #(
  parameter int AW = 4,
  parameter int DW = 8
) (
  // clock
  input wire logic mclk,
  // access port
  page_mem_if.mem p
);
  logic [DW-1:0] mem_reg [2**AW];

  always_ff @(posedge mclk) begin
    if (p.wr_en) begin
      mem_reg[p.wr_addr] <= p.wr_data;
    end
    p.rd_data <= mem_reg[p.rd_addr];
  end
endmodule // page_mem
`default_nettype wire
